// [src/reset_source_flag_logic.sv]
// Reset source merging and reset-cause flag registers behind an APB slave.
//
// How it works
// - Five sources all drive one system reset.
// - Ordinary registers reload; only flags depend on source.
// - Cold-start flag set when power-on completes.
// - Other resets keep cold-start; software clears it.
// - Droop reset sets droop-reset flag.
// - Droop-reset flag kept except by power-on.
// - Software clears droop-reset flag by writing zero.
// - Soft reset sets soft-reset flag, software clears.
// - Watchdog reset sets watchdog flag, software clears.
// - Supply low holds core reset, no fetch.
// - Supply good: oscillator, release, fetch 0000H.
// - Data RAM not cleared by power-on.
// - Droop resets only when reset enable set.
// - Droop event flag loaded by table.
// - Enables reload from configuration bits 7, 4.
`timescale 1ns/1ns
`include "reset_ctrl_map.svh"

module reset_source_flag_logic
    import reset_ctrl_pkg::*;
(
    input wire logic pclk, // APB and system clock.
    input wire logic presetn, // Asynchronous bus reset, active low.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic supply_above_por, // Power-on reference: supply good.
    input wire logic supply_below_droop, // Droop comparator: supply under trigger.
    input wire logic reset_pin, // External reset pin, active high.
    input wire logic watchdog_timeout, // Watchdog time-out pulse.
    input wire logic [7:0] config_byte_two, // Configuration byte.
    output logic system_reset, // Merged system reset, active high.
    output logic osc_enable, // Selected oscillator run enable.
    output logic fetch_enable, // Program fetch allowed.
    output logic [15:0] fetch_address, // Start address of instruction fetch.
    output logic irq // Level interrupt.
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        phase_e phase;
        cause_e cause;
        logic [1:0] hold;
        logic [1:0] pin_count;
        logic [7:0] power_control;
        logic [7:0] reset_cause_status;
        logic [7:0] watchdog_control;
        logic [7:0] power_monitor_control;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic droop_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic system_reset;
        logic osc_enable;
        logic fetch_enable;
        logic irq;
    } state_s;

    state_s r;
    state_s next_r;

    // Write strobe of the low byte in the access phase.
    function automatic logic wr_hit(input logic [11:0] a, input logic [9:0] idx);
        wr_hit = psel && penable && pwrite && pstrb[0] && (a == {idx, 2'b00});
    endfunction : wr_hit

    logic [7:0] wbyte;
    logic rd_mapped;
    logic soft_req;
    logic droop_req;
    logic droop_edge;

    assign wbyte = pwdata[7:0];

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_r = r;
        soft_req = 1'b0;
        droop_edge = supply_below_droop && !r.droop_prev;
        // Droop only resets with detection and reset enabled.
        droop_req = supply_below_droop && r.power_monitor_control[`POS_RESET_ENABLE]
            && r.power_monitor_control[`POS_DETECT_ENABLE];
        next_r.droop_prev = supply_below_droop;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        next_r.prdata = 32'h0000_0000;
        rd_mapped = 1'b1;
        // Pin must be seen high for the hold count before it counts as a reset.
        if (reset_pin) begin
            if (r.pin_count != 2'(`HOLD_CYCLES)) begin
                next_r.pin_count = r.pin_count + 2'h1;
            end
        end else begin
            next_r.pin_count = 2'h0;
        end
        // Register bus; ready rises in the cycle after the first access cycle.
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            unique case (paddr)
                `ADDR_OF(`IDX_POWER_CONTROL): next_r.prdata = {24'h0, r.power_control};
                `ADDR_OF(`IDX_RESET_CAUSE): next_r.prdata = {24'h0, r.reset_cause_status};
                `ADDR_OF(`IDX_WATCHDOG_CONTROL): next_r.prdata = {24'h0, r.watchdog_control};
                `ADDR_OF(`IDX_POWER_MONITOR): begin
                    next_r.prdata = {24'h0, r.power_monitor_control[7:1],
                        supply_below_droop && r.power_monitor_control[`POS_DETECT_ENABLE]};
                end
                `ADDR_OF(`IDX_RESET_CTRL): next_r.prdata = 32'h0000_0000;
                `ADDR_OF(`IDX_IRQ_STATUS): next_r.prdata = {29'h0, r.irq_status};
                `ADDR_OF(`IDX_IRQ_MASK): next_r.prdata = {29'h0, r.irq_mask};
                default: rd_mapped = 1'b0;
            endcase
            next_r.pslverr = !rd_mapped;
            if (r.phase == ST_RUN && !r.pready) begin
                if (wr_hit(paddr, `IDX_POWER_CONTROL)) begin
                    next_r.power_control = wbyte & 8'h9f;
                end
                if (wr_hit(paddr, `IDX_RESET_CAUSE)) begin
                    next_r.reset_cause_status = wbyte & 8'h05;
                end
                if (wr_hit(paddr, `IDX_WATCHDOG_CONTROL)) begin
                    next_r.watchdog_control = wbyte & 8'hdf;
                end
                if (wr_hit(paddr, `IDX_POWER_MONITOR)) begin
                    next_r.power_monitor_control = wbyte & 8'h9e;
                end
                if (wr_hit(paddr, `IDX_RESET_CTRL)) begin
                    soft_req = wbyte[0];
                end
                if (wr_hit(paddr, `IDX_IRQ_MASK)) begin
                    next_r.irq_mask = wbyte[2:0];
                end
            end
        end
        // Status bits: set wins over write-one-to-clear.
        if (r.phase == ST_RUN && wr_hit(paddr, `IDX_IRQ_STATUS) && !r.pready) begin
            next_r.irq_status = r.irq_status & ~wbyte[2:0];
        end
        if (droop_edge && r.power_monitor_control[`POS_DETECT_ENABLE]) begin
            next_r.power_monitor_control[`POS_DROOP_EVENT] = 1'b1;
            next_r.irq_status[0] = 1'b1;
        end
        // Reset sequencing.
        unique case (r.phase)
            ST_POWER_HOLD: begin
                if (supply_above_por) begin
                    next_r.phase = ST_IN_RESET;
                    next_r.cause = CAUSE_POWER_ON;
                    next_r.osc_enable = 1'b1;
                    next_r.hold = 2'h0;
                end
            end
            ST_RUN: begin
                // All five sources merge into one reset.
                if (!supply_above_por) begin
                    next_r.phase = ST_POWER_HOLD;
                    next_r.osc_enable = 1'b0;
                end else if (droop_req || r.pin_count == 2'(`HOLD_CYCLES) || soft_req
                        || watchdog_timeout) begin
                    next_r.phase = ST_IN_RESET;
                    next_r.hold = 2'h0;
                    next_r.cause = droop_req ? CAUSE_DROOP : watchdog_timeout ? CAUSE_WATCHDOG
                        : soft_req ? CAUSE_SOFT : CAUSE_PIN;
                end
            end
            ST_IN_RESET: begin
                if (!supply_above_por) begin
                    next_r.phase = ST_POWER_HOLD;
                    next_r.osc_enable = 1'b0;
                end else if (r.hold != 2'h1 || reset_pin
                        || (r.cause == CAUSE_DROOP && supply_below_droop)) begin
                    next_r.hold = 2'h1;
                end else begin
                    // Release: ordinary registers reload, flags by cause.
                    next_r.phase = ST_RUN;
                    next_r.watchdog_control = r.watchdog_control & 8'h08;
                    next_r.power_control = r.power_control & 8'h10;
                    next_r.irq_status = 3'h0;
                    next_r.irq_mask = 3'h0;
                    next_r.power_monitor_control = `RST_BYTE;
                    next_r.power_monitor_control[`POS_DETECT_ENABLE] =
                        config_byte_two[`POS_CFG_DETECT];
                    next_r.power_monitor_control[`POS_RESET_ENABLE] =
                        config_byte_two[`POS_CFG_RESET];
                    // Droop event reload table.
                    next_r.power_monitor_control[`POS_DROOP_EVENT] =
                        config_byte_two[`POS_CFG_DETECT] && ((r.cause == CAUSE_DROOP
                        && config_byte_two[`POS_CFG_RESET]) || !config_byte_two[`POS_CFG_RESET]
                        && !supply_below_droop);
                    if (r.cause == CAUSE_POWER_ON) begin
                        next_r.power_control[`POS_COLD_START] = 1'b1;
                        next_r.reset_cause_status = 8'h00;
                        next_r.watchdog_control = 8'h00;
                    end
                    if (r.cause == CAUSE_DROOP) begin
                        next_r.reset_cause_status[`POS_DROOP_RESET] = 1'b1;
                    end
                    if (r.cause == CAUSE_SOFT) begin
                        next_r.reset_cause_status[`POS_SOFT_RESET] = 1'b1;
                    end
                    if (r.cause == CAUSE_WATCHDOG) begin
                        next_r.watchdog_control[`POS_WATCHDOG_RESET] = 1'b1;
                    end
                    next_r.irq_status[1] = 1'b1;
                    next_r.cause = CAUSE_NONE;
                end
            end
        endcase
        next_r.system_reset = (next_r.phase != ST_RUN);
        next_r.fetch_enable = (next_r.phase == ST_RUN);
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    end

    // ------------------------------------------------------------------------
    // Registers; data RAM is elsewhere and not touched by any reset.
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{phase: ST_POWER_HOLD, cause: CAUSE_NONE, system_reset: 1'b1,
                default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign system_reset = r.system_reset;
    assign osc_enable = r.osc_enable;
    assign fetch_enable = r.fetch_enable;
    assign fetch_address = 16'h0000;
    assign irq = r.irq;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_release;
        r.phase == ST_IN_RESET ##1 r.phase == ST_RUN;
    endsequence

    property p_hold_low_supply;
        @(posedge pclk) disable iff (!presetn)
        !supply_above_por |=> system_reset && !fetch_enable;
    endproperty
    a_hold_low_supply: assert property (p_hold_low_supply)
        else $error("Fetch allowed with supply low.");

    property p_cold_start;
        @(posedge pclk) disable iff (!presetn)
        (r.phase == ST_IN_RESET && r.cause == CAUSE_POWER_ON && next_r.phase == ST_RUN)
            |=> r.power_control[4] && r.reset_cause_status[2] == 1'b0;
    endproperty
    a_cold_start: assert property (p_cold_start)
        else $error("Cold start flag not set after power-on.");

    property p_keep_cold;
        @(posedge pclk) disable iff (!presetn)
        (r.cause inside {CAUSE_PIN, CAUSE_SOFT, CAUSE_WATCHDOG, CAUSE_DROOP} ##1 r.phase == ST_RUN)
            |-> r.power_control[4] == $past(r.power_control[4]);
    endproperty
    a_keep_cold: assert property (p_keep_cold)
        else $error("Warm reset changed cold start flag.");

    property p_droop_flag;
        @(posedge pclk) disable iff (!presetn)
        (r.cause == CAUSE_DROOP) ##1 (r.phase == ST_RUN) |-> r.reset_cause_status[2];
    endproperty
    a_droop_flag: assert property (p_droop_flag)
        else $error("Droop reset flag missing.");

    property p_soft_flag;
        @(posedge pclk) disable iff (!presetn)
        (r.cause == CAUSE_SOFT) ##1 (r.phase == ST_RUN) |-> r.reset_cause_status[0];
    endproperty
    a_soft_flag: assert property (p_soft_flag)
        else $error("Soft reset flag missing.");

    property p_wdt_flag;
        @(posedge pclk) disable iff (!presetn)
        (r.cause == CAUSE_WATCHDOG) ##1 (r.phase == ST_RUN) |-> r.watchdog_control[3];
    endproperty
    a_wdt_flag: assert property (p_wdt_flag)
        else $error("Watchdog reset flag missing.");

    property p_reload;
        @(posedge pclk) disable iff (!presetn)
        s_release |-> r.power_monitor_control[7] == $past(config_byte_two[7])
            && r.power_monitor_control[4] == $past(config_byte_two[4]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("Droop enables not reloaded.");

    property p_no_droop_reset;
        @(posedge pclk) disable iff (!presetn)
        (r.phase == ST_RUN && supply_above_por && !r.power_monitor_control[4] && !reset_pin
            && r.pin_count == 2'h0 && !watchdog_timeout && !(psel && pwrite))
            |=> !system_reset;
    endproperty
    a_no_droop_reset: assert property (p_no_droop_reset)
        else $error("Reset without enabled cause.");

    // A warm reset other than a droop reset leaves the droop-reset flag alone.
    property p_droop_kept;
        @(posedge pclk) disable iff (!presetn)
        (r.phase == ST_IN_RESET && next_r.phase == ST_RUN
            && r.cause inside {CAUSE_PIN, CAUSE_SOFT, CAUSE_WATCHDOG})
            |=> r.reset_cause_status[2] == $past(r.reset_cause_status[2]);
    endproperty
    a_droop_kept: assert property (p_droop_kept)
        else $error("Warm reset changed droop reset flag.");

    // Ordinary bits return to their reset values at every release.
    property p_reg_reload;
        @(posedge pclk) disable iff (!presetn)
        s_release |-> r.irq_mask == 3'h0 && (r.power_control & 8'hef) == 8'h00;
    endproperty
    a_reg_reload: assert property (p_reg_reload)
        else $error("Ordinary register not reloaded at release.");

    // A pin held long enough while running starts a reset.
    property p_pin_reset;
        @(posedge pclk) disable iff (!presetn)
        (r.phase == ST_RUN && supply_above_por && r.pin_count == 2'(`HOLD_CYCLES))
            |=> system_reset;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("Pin request did not reset.");

    // With detection disabled in the configuration the droop event reloads as zero.
    property p_event_off;
        @(posedge pclk) disable iff (!presetn)
        (r.phase == ST_IN_RESET && next_r.phase == ST_RUN && !config_byte_two[7])
            |=> !r.power_monitor_control[3];
    endproperty
    a_event_off: assert property (p_event_off)
        else $error("Droop event set with detection disabled.");

endmodule : reset_source_flag_logic

// [src/reset_ctrl_map.svh]
// Register offsets, field positions, reset values and timing counts of the reset controller.
`ifndef RESET_CTRL_MAP_SVH
`define RESET_CTRL_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define IDX_POWER_CONTROL 10'h087
`define IDX_RESET_CAUSE 10'h096
`define IDX_WATCHDOG_CONTROL 10'h0aa
`define IDX_POWER_MONITOR 10'h0ac
`define IDX_RESET_CTRL 10'h0c0
`define IDX_IRQ_STATUS 10'h0c1
`define IDX_IRQ_MASK 10'h0c2
`define ADDR_OF(idx) ({idx, 2'b00})

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define POS_COLD_START 4
`define POS_DROOP_RESET 2
`define POS_SOFT_RESET 0
`define POS_WATCHDOG_RESET 3
`define POS_DETECT_ENABLE 7
`define POS_RESET_ENABLE 4
`define POS_DROOP_EVENT 3
`define POS_DROOP_STATUS 0
`define POS_CFG_DETECT 7
`define POS_CFG_RESET 4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define HOLD_TIME_NS 20
`define CLK_PERIOD_NS 10
`define HOLD_CYCLES ((`HOLD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [src/reset_ctrl_pkg.sv]
// Types shared by the reset controller.
package reset_ctrl_pkg;

    // Cause latched for the reset currently being applied.
    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_POWER_ON,
        CAUSE_PIN,
        CAUSE_SOFT,
        CAUSE_WATCHDOG,
        CAUSE_DROOP
    } cause_e;

    // Sequencer phases.
    typedef enum logic [1:0] {
        ST_POWER_HOLD,
        ST_RUN,
        ST_IN_RESET
    } phase_e;

endpackage : reset_ctrl_pkg

// [verif/reset_requester_model.sv]
// Behavioural model of the supply monitors, watchdog, reset pin and configuration byte.
`timescale 1ns/1ns
module reset_requester_model (
    input wire logic pclk, // System clock.
    output logic supply_above_por, // Supply above the power-on threshold.
    output logic supply_below_droop, // Supply under the droop trigger level.
    output logic reset_pin, // External reset request, active high.
    output logic watchdog_timeout, // Watchdog time-out request.
    output logic [7:0] config_byte_two // Configuration byte.
);
    // Supply starts low so the controller begins in its power hold.
    initial begin
        supply_above_por = 1'b0;
        supply_below_droop = 1'b0;
        reset_pin = 1'b0;
        watchdog_timeout = 1'b0;
        config_byte_two = 8'h00;
    end

    // Load the configuration byte that the next reset release picks up.
    task automatic set_cfg(input logic [7:0] v);
        @(posedge pclk);
        config_byte_two <= v;
    endtask : set_cfg

    // Raise one request for n cycles: 0 supply loss, 1 pin, 2 watchdog, 3 droop.
    task automatic hold(input int src, input int n);
        @(posedge pclk);
        case (src)
            0: supply_above_por <= 1'b0;
            1: reset_pin <= 1'b1; // Callers hold the pin two cycles or more.
            2: watchdog_timeout <= 1'b1;
            default: supply_below_droop <= 1'b1;
        endcase
        repeat (n) @(posedge pclk);
        supply_above_por <= 1'b1;
        reset_pin <= 1'b0;
        watchdog_timeout <= 1'b0;
        supply_below_droop <= 1'b0;
    endtask : hold
endmodule : reset_requester_model

// [verif/reset_source_flag_logic_tb_top.sv]
// Self-checking testbench of the reset source flag logic.
`timescale 1ns/1ns
`include "reset_ctrl_map.svh"
module reset_source_flag_logic_tb_top;
    localparam logic [11:0] A_PC = `ADDR_OF(`IDX_POWER_CONTROL);
    localparam logic [11:0] A_RS = `ADDR_OF(`IDX_RESET_CAUSE);
    localparam logic [11:0] A_WD = `ADDR_OF(`IDX_WATCHDOG_CONTROL);
    localparam logic [11:0] A_PM = `ADDR_OF(`IDX_POWER_MONITOR);
    localparam logic [11:0] A_RC = `ADDR_OF(`IDX_RESET_CTRL);
    localparam logic [11:0] A_IS = `ADDR_OF(`IDX_IRQ_STATUS);
    localparam logic [11:0] A_IM = `ADDR_OF(`IDX_IRQ_MASK);
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic supply_above_por, supply_below_droop, reset_pin, watchdog_timeout;
    logic system_reset, osc_enable, fetch_enable, irq;
    logic [7:0] config_byte_two;
    logic [15:0] fetch_address;
    int bad_count = 0;
    int compares = 0;

    // Clock of 10 ns period.
    always #5 pclk = ~pclk;

    reset_source_flag_logic dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_above_por(supply_above_por),
        .supply_below_droop(supply_below_droop), .reset_pin(reset_pin),
        .watchdog_timeout(watchdog_timeout), .config_byte_two(config_byte_two),
        .system_reset(system_reset), .osc_enable(osc_enable), .fetch_enable(fetch_enable),
        .fetch_address(fetch_address), .irq(irq));

    reset_requester_model m (.pclk(pclk), .supply_above_por(supply_above_por),
        .supply_below_droop(supply_below_droop), .reset_pin(reset_pin),
        .watchdog_timeout(watchdog_timeout), .config_byte_two(config_byte_two));

    // ------------------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------------------

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // Compares one value and reports a mismatch.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        chk("pready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1) end_of_test();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads a register and compares the masked bits.
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] msk,
                        input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(n, e, rd & msk);
    endtask : rchk

    // Waits for a reset to be applied and for the core to run again.
    task automatic wait_reset();
        int i;
        for (i = 0; i < 40 && system_reset !== 1'b1; i++) @(posedge pclk);
        chk("system_reset", 32'h1, {31'h0, system_reset});
        for (i = 0; i < 80 && fetch_enable !== 1'b1; i++) @(posedge pclk);
        chk("fetch_enable", 32'h1, {31'h0, fetch_enable});
        if (fetch_enable !== 1'b1) end_of_test();
        @(posedge pclk);
    endtask : wait_reset

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("fetch while supply low", 32'h0, {31'h0, fetch_enable});
        chk("reset while supply low", 32'h1, {31'h0, system_reset});
        chk("osc off while supply low", 32'h0, {31'h0, osc_enable});
        m.hold(0, 1);
        wait_reset();
        chk("osc_enable", 32'h1, {31'h0, osc_enable});
        chk("fetch_address", 32'h0, {16'h0, fetch_address});
        rchk("cold start", A_PC, 32'h10, 32'h10);
        rchk("cause after power-on", A_RS, 32'h05, 32'h0);
        apb(A_PC, 1'b1, 32'h0);
        rchk("cold start cleared", A_PC, 32'h10, 32'h0);
        // Software reset, then the interrupt path.
        apb(A_RC, 1'b1, 32'h1);
        wait_reset();
        rchk("soft flag", A_RS, 32'h05, 32'h01);
        rchk("cold start kept", A_PC, 32'h10, 32'h0);
        apb(A_IM, 1'b1, 32'h3);
        rchk("irq status", A_IS, 32'h02, 32'h02);
        repeat (2) @(posedge pclk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(A_IM, 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(A_IM, 1'b1, 32'h3);
        apb(A_IS, 1'b1, 32'h3);
        rchk("irq status cleared", A_IS, 32'h03, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(A_RS, 1'b1, 32'h0);
        rchk("soft flag cleared", A_RS, 32'h01, 32'h0);
        // Watchdog reset.
        m.hold(2, 1);
        wait_reset();
        rchk("watchdog flag", A_WD, 32'h08, 32'h08);
        rchk("mask reloaded", A_IM, 32'h07, 32'h0);
        apb(A_WD, 1'b1, 32'h0);
        rchk("watchdog flag cleared", A_WD, 32'h08, 32'h0);
        // Droop resets with both configuration enables set.
        m.set_cfg(8'h90);
        m.hold(1, 2);
        wait_reset();
        rchk("enables loaded", A_PM, 32'h90, 32'h90);
        rchk("pin leaves flags", A_RS, 32'h05, 32'h0);
        m.hold(3, 3);
        wait_reset();
        rchk("droop flag", A_RS, 32'h05, 32'h04);
        rchk("droop event", A_PM, 32'h98, 32'h98);
        apb(A_PM, 1'b1, 32'h90);
        rchk("droop event cleared", A_PM, 32'h98, 32'h90);
        apb(A_RS, 1'b1, 32'h0);
        rchk("droop flag cleared", A_RS, 32'h04, 32'h0);
        m.hold(3, 3);
        wait_reset();
        m.set_cfg(8'h80);
        m.hold(1, 2);
        wait_reset();
        rchk("droop flag kept", A_RS, 32'h04, 32'h04);
        rchk("event, no reset enable", A_PM, 32'h98, 32'h88);
        m.hold(3, 4);
        repeat (2) @(posedge pclk);
        chk("no droop reset", 32'h0, {31'h0, system_reset});
        m.hold(0, 3);
        wait_reset();
        rchk("droop flag by power-on", A_RS, 32'h04, 32'h0);
        rchk("cold start again", A_PC, 32'h10, 32'h10);
        m.set_cfg(8'h00);
        m.hold(1, 2);
        wait_reset();
        rchk("event, detect off", A_PM, 32'h98, 32'h0);
        apb(12'h000, 1'b0, 32'h0);
        chk("pslverr unmapped", 32'h1, {31'h0, err});
        end_of_test();
    end
endmodule : reset_source_flag_logic_tb_top
